/* hw/odm_pkg.sv */
// Package for the opcode decode and execute map.
// Shared by the decoder top, its I/O subcode decoder and the testbench; nothing else assumed.
package odm_pkg;

    // ------------------------
    // Word layout
    // ------------------------
    localparam int WORD_W     = 24;  // Machine word width
    localparam int OPC_MSB    = 23;  // Operation field, two octal digits
    localparam int OPC_LSB    = 18;
    localparam int BSEL_MSB   = 17;  // Index designator b (0 means none)
    localparam int BSEL_LSB   = 16;
    localparam int FORM_BIT   = 15;  // Alternate form select
    localparam int ADDR_W     = 15;  // Word address / operand y width
    localparam int CHAR_W     = 17;  // Character address width
    localparam int SUB_MSB    = 17;  // Opcode 77 first subcode digit
    localparam int SUB_LSB    = 15;
    localparam int SUB2_MSB   = 14;  // Opcode 77 second subcode digit
    localparam int SUB2_LSB   = 12;

    // ------------------------
    // Operation codes (octal)
    // ------------------------
    localparam logic [5:0] OPC_SKIP_GE    = 6'o05;
    localparam logic [5:0] OPC_INDEX_SKIP = 6'o10;
    localparam logic [5:0] OPC_ENTER_CHA  = 6'o11;
    localparam logic [5:0] OPC_XOR        = 6'o16;
    localparam logic [5:0] OPC_AND        = 6'o17;
    localparam logic [5:0] OPC_LOAD_DBL   = 6'o25;
    localparam logic [5:0] OPC_STORE_WA   = 6'o44;
    localparam logic [5:0] OPC_STORE_CA   = 6'o46;
    localparam logic [5:0] OPC_DIVIDE     = 6'o51;
    localparam logic [5:0] OPC_UNUSED     = 6'o55;
    localparam logic [5:0] OPC_TRAP_LO    = 6'o56;
    localparam logic [5:0] OPC_TRAP_HI    = 6'o70;
    localparam logic [5:0] OPC_MOVE       = 6'o72;
    localparam logic [5:0] OPC_IN_CHAR    = 6'o73;
    localparam logic [5:0] OPC_OUT_WORD   = 6'o76;
    localparam logic [5:0] OPC_IO_CTRL    = 6'o77;

    // Store masks for the address store forms
    localparam logic [23:0] MASK_WORD_ADDR = 24'h007fff;
    localparam logic [23:0] MASK_CHAR_ADDR = 24'h01ffff;
    localparam logic [23:0] MASK_FULL      = 24'hffffff;
    localparam logic [23:0] WORD_RESET     = 24'h000000;

    // ------------------------
    // Operation classes handed to the datapath
    // ------------------------
    typedef enum logic [4:0] {
        OP_NONE, OP_SKIP_ACC_GE, OP_SKIP_Q_LE, OP_SKIP_IDX_LE,
        OP_IDX_SKIP_INC, OP_IDX_SKIP_DEC, OP_STORAGE_SHIFT, OP_ENTER_CHA,
        OP_XOR, OP_AND, OP_LOAD_DOUBLE, OP_STORE_WORD_ADDR,
        OP_STORE_CHAR_ADDR, OP_DIVIDE_DS, OP_MOVE_CHARS, OP_IN_CHAR_BLOCK,
        OP_IN_CHAR_ACC, OP_OUT_WORD_BLOCK, OP_OUT_WORD_ACC, OP_IO_CONTROL,
        OP_OTHER_NATIVE, OP_TRAP
    } odm_op_e;

    // Destination of a computed result
    typedef enum logic [2:0] {
        DEST_NONE, DEST_A, DEST_Q, DEST_IDX, DEST_AQ, DEST_MEM
    } odm_dest_e;

    // Decoded instruction as handed to the execution datapath
    typedef struct packed {
        odm_op_e     op;       // Operation class
        odm_dest_e   dest;     // Where result goes
        logic        skip;     // Skip the following instruction
        logic        trap;     // Route to trap path
        logic        illegal;  // Unassigned code or subcode
        logic [5:0]  opcode;   // Raw operation field
        logic [1:0]  bsel;     // Index designator
        logic [5:0]  subcode;  // Opcode 77 subcode, two digits
        logic [23:0] result;   // Computed value for dest
        logic [23:0] wmask;    // Bits written when dest is memory
    } odm_dec_s;

endpackage

/* hw/odm_io_subcode.sv */
// Subcode checker for the opcode 77 I/O and interrupt group.
// Assumes the two subcode digits come straight from the instruction word.
`timescale 1ns/1ns
module odm_io_subcode
    import odm_pkg::*;
(
    input  wire logic [2:0] SUB_HI,  // First subcode digit
    input  wire logic [2:0] SUB_LO,  // Second subcode digit
    input  wire logic [2:0] XFIELD,  // x field, top digit of address
    output logic            ASSIGNED // Subcode has a meaning
);
    // ------------------------
    // Group 5 holds only 50..53 and 57; the others are free
    // ------------------------
    wire logic grp5_ok;  // Interrupt clear/mask family
    wire logic grp23_ok; // Sense forms need a nonzero x for 2x/3x
    assign grp5_ok  = (SUB_LO <= 3'h3) || (SUB_LO == 3'h7);
    // 20 and 30 are copy forms with x zero; any other second digit needs x
    assign grp23_ok = (SUB_LO == 3'h0) || (XFIELD != 3'h0);

    // Selection of the group answer
    assign ASSIGNED = (SUB_HI == 3'h5) ? grp5_ok :
                      ((SUB_HI == 3'h2) || (SUB_HI == 3'h3)) ? grp23_ok :
                      1'b1;
endmodule

/* hw/odm_decode.sv */
// Opcode decode and execute map: the operation field to operation class.
// Sits between instruction fetch and the execution datapath, one clock.
`timescale 1ns/1ns
module odm_decode
    import odm_pkg::*;
#(
    parameter int WORD_BITS = WORD_W  // Data word width
)
(
    input  wire logic              CLK,          // 125 MHz core clock
    input  wire logic              RST,          // Synchronous, active high
    input  wire logic [23:0]       INSTR,        // Fetched instruction word
    input  wire logic              INSTR_VALID,  // Fetch offers a word
    output logic                   INSTR_READY,  // Decoder takes the word
    input  wire logic [23:0]       ACC,          // Accumulator A
    input  wire logic [23:0]       QREG,         // Q register
    input  wire logic [14:0]       IDX,          // Index selected by b
    output odm_pkg::odm_dec_s      DEC,          // Decoded instruction
    output logic                   DEC_VALID,    // DEC holds a result
    input  wire logic              DEC_READY     // Datapath accepts DEC
);
    import odm_pkg::*;

    // ------------------------
    // Elaboration check
    // ------------------------
    // The field layout is fixed to a 24-bit word
    if (WORD_BITS != WORD_W) begin : g_bad_width
        $error("odm_decode supports only a 24-bit word");
    end

    // ------------------------
    // Ones complement helpers
    // ------------------------
    // Map a ones complement word to twos complement, 25 bits wide.
    // Negative zero folds onto zero so both zeros compare equal.
    function automatic logic signed [24:0] oc_value(input logic [23:0] w);
        logic signed [24:0] v;
        v = signed'({w[23], w});
        if (w[23]) begin
            v = v + 25'sd1;
        end
        return v;
    endfunction

    // Ones complement add of a 15-bit index with end-around carry
    function automatic logic [14:0] oc_add15(input logic [14:0] a,
                                             input logic [14:0] b);
        logic [15:0] s;
        s = {1'b0, a} + {1'b0, b};
        s = {1'b0, s[14:0]} + {15'h0000, s[15]};
        // A zero result is given as positive zero
        if (s[14:0] == 15'h7fff) begin
            s[14:0] = 15'h0000;
        end
        return s[14:0];
    endfunction

    // Sign extend a 15-bit operand y to a full word
    function automatic logic [23:0] ext_y(input logic [14:0] y);
        return {{9{y[14]}}, y};
    endfunction

    // ------------------------
    // Field split
    // ------------------------
    wire logic [5:0]  opc;       // Operation field
    wire logic [1:0]  bsel;      // Index designator
    wire logic        form;      // Alternate form bit
    wire logic [14:0] y_fld;     // Operand y / address m
    wire logic [16:0] z_fld;     // Character address z
    wire logic [2:0]  sub_hi;    // Opcode 77 first digit
    wire logic [2:0]  sub_lo;    // Opcode 77 second digit
    wire logic [23:0] y_word;    // y widened to a word
    wire logic [23:0] idx_word;  // Index widened to a word
    assign opc      = INSTR[OPC_MSB:OPC_LSB];
    assign bsel     = INSTR[BSEL_MSB:BSEL_LSB];
    assign form     = INSTR[FORM_BIT];
    assign y_fld    = INSTR[ADDR_W-1:0];
    assign z_fld    = INSTR[CHAR_W-1:0];
    assign sub_hi   = INSTR[SUB_MSB:SUB_LSB];
    assign sub_lo   = INSTR[SUB2_MSB:SUB2_LSB];
    assign y_word   = ext_y(y_fld);
    assign idx_word = ext_y(IDX);

    // ------------------------
    // Compares and index stepping
    // ------------------------
    wire logic        a_ge_y;    // (A) >= y
    wire logic        q_le_y;    // (Q) <= y
    wire logic        i_le_y;    // (B) <= y
    wire logic        i_eq_y;    // (B) == y, end of index count
    wire logic [14:0] idx_inc;   // Index plus one
    wire logic [14:0] idx_dec;   // Index minus one
    assign a_ge_y  = oc_value(ACC) >= oc_value(y_word);
    assign q_le_y  = oc_value(QREG) <= oc_value(y_word);
    assign i_le_y  = oc_value(idx_word) <= oc_value(y_word);
    assign i_eq_y  = oc_value(idx_word) == oc_value(y_word);
    assign idx_inc = oc_add15(IDX, 15'h0001);
    // Adding negative one in ones complement steps the index down
    assign idx_dec = oc_add15(IDX, 15'h7ffe);

    // ------------------------
    // Logical results, shared by opcodes 16 and 17
    // ------------------------
    wire logic [23:0] logic_src;  // Register chosen by b and form
    wire odm_dest_e   logic_dest; // Matching destination
    wire logic [23:0] xor_res;    // Exclusive OR result
    wire logic [23:0] and_res;    // AND result
    assign logic_src  = (bsel != 2'b00) ? idx_word : (form ? QREG : ACC);
    assign logic_dest = (bsel != 2'b00) ? DEST_IDX : (form ? DEST_Q : DEST_A);
    assign xor_res    = y_word ^ logic_src;
    assign and_res    = y_word & logic_src;

    // ------------------------
    // Opcode 77 subcode check
    // ------------------------
    wire logic sub_ok;  // Subcode is assigned
    odm_io_subcode u_sub (
        .SUB_HI   (sub_hi),
        .SUB_LO   (sub_lo),
        .XFIELD   (sub_lo),
        .ASSIGNED (sub_ok)
    );

    // ------------------------
    // Operation map
    // ------------------------
    odm_dec_s next_dec;  // Decode of the word on INSTR
    always_comb begin
        next_dec         = '0;
        next_dec.op      = OP_OTHER_NATIVE;
        next_dec.dest    = DEST_NONE;
        next_dec.opcode  = opc;
        next_dec.bsel    = bsel;
        next_dec.wmask   = MASK_FULL;
        next_dec.result  = WORD_RESET;
        case (opc)
            OPC_SKIP_GE: begin
                // Index form wins over the A and Q forms
                if (bsel != 2'b00) begin
                    next_dec.op   = OP_SKIP_IDX_LE;
                    next_dec.skip = i_le_y;
                end else if (form) begin
                    next_dec.op   = OP_SKIP_Q_LE;
                    next_dec.skip = q_le_y;
                end else begin
                    next_dec.op   = OP_SKIP_ACC_GE;
                    next_dec.skip = a_ge_y;
                end
            end
            OPC_INDEX_SKIP: begin
                // With no index named this is the storage shift form
                if (bsel == 2'b00) begin
                    next_dec.op = OP_STORAGE_SHIFT;
                end else begin
                    next_dec.op     = form ? OP_IDX_SKIP_DEC : OP_IDX_SKIP_INC;
                    next_dec.dest   = DEST_IDX;
                    next_dec.skip   = i_eq_y;
                    next_dec.result = ext_y(form ? idx_dec : idx_inc);
                end
            end
            OPC_ENTER_CHA: begin
                next_dec.op     = OP_ENTER_CHA;
                next_dec.dest   = DEST_A;
                next_dec.result = {7'h00, z_fld};
            end
            OPC_XOR: begin
                next_dec.op     = OP_XOR;
                next_dec.dest   = logic_dest;
                next_dec.result = xor_res;
            end
            OPC_AND: begin
                next_dec.op     = OP_AND;
                next_dec.dest   = logic_dest;
                next_dec.result = and_res;
            end
            OPC_LOAD_DBL: begin
                // Datapath reads two words into A then Q
                next_dec.op   = OP_LOAD_DOUBLE;
                next_dec.dest = DEST_AQ;
            end
            OPC_STORE_WA: begin
                // Only the address part of the word is written
                next_dec.op     = OP_STORE_WORD_ADDR;
                next_dec.dest   = DEST_MEM;
                next_dec.wmask  = MASK_WORD_ADDR;
                next_dec.result = ACC & MASK_WORD_ADDR;
            end
            OPC_STORE_CA: begin
                next_dec.op     = OP_STORE_CHAR_ADDR;
                next_dec.dest   = DEST_MEM;
                next_dec.wmask  = MASK_CHAR_ADDR;
                next_dec.result = ACC & MASK_CHAR_ADDR;
            end
            OPC_DIVIDE: begin
                // Quotient and remainder return to A and Q
                next_dec.op   = OP_DIVIDE_DS;
                next_dec.dest = DEST_AQ;
            end
            OPC_UNUSED: begin
                next_dec.op      = OP_NONE;
                next_dec.illegal = 1'b1;
            end
            OPC_MOVE: begin
                next_dec.op = OP_MOVE_CHARS;
            end
            OPC_IN_CHAR: begin
                // Single character form lands in A
                next_dec.op   = form ? OP_IN_CHAR_ACC : OP_IN_CHAR_BLOCK;
                next_dec.dest = form ? DEST_A : DEST_MEM;
            end
            OPC_OUT_WORD: begin
                next_dec.op     = form ? OP_OUT_WORD_ACC : OP_OUT_WORD_BLOCK;
                next_dec.result = form ? ACC : WORD_RESET;
            end
            OPC_IO_CTRL: begin
                next_dec.op      = sub_ok ? OP_IO_CONTROL : OP_NONE;
                next_dec.subcode = {sub_hi, sub_lo};
                next_dec.illegal = !sub_ok;
            end
            default: begin
                // Extended arithmetic, floating point and E register ops
                if ((opc >= OPC_TRAP_LO) && (opc <= OPC_TRAP_HI)) begin
                    next_dec.op   = OP_TRAP;
                    next_dec.trap = 1'b1;
                end
            end
        endcase
    end

    // ------------------------
    // Handshake state
    // ------------------------
    // Gray path: empty -> holding -> empty
    typedef enum logic [0:0] {
        ST_EMPTY = 1'b0,  // Nothing offered downstream
        ST_HOLD  = 1'b1   // DEC waits for the datapath
    } odm_state_e;

    odm_state_e state;       // Present state
    odm_state_e next_state;  // State for the next edge
    wire logic  take;        // An instruction is taken this cycle
    wire logic  drain;       // The datapath takes DEC this cycle

    // A held result may be replaced in the cycle it drains, so the
    // decoder sustains one word per clock without a bubble.
    assign drain       = (state == ST_HOLD) && DEC_READY;
    assign INSTR_READY = (state == ST_EMPTY) || DEC_READY;
    assign take        = INSTR_VALID && INSTR_READY;
    assign DEC_VALID   = (state == ST_HOLD);

    always_comb begin
        case (state)
            ST_EMPTY: next_state = take ? ST_HOLD : ST_EMPTY;
            ST_HOLD:  next_state = (drain && !take) ? ST_EMPTY : ST_HOLD;
            default:  next_state = ST_EMPTY;
        endcase
    end

    // ------------------------
    // Registers
    // ------------------------
    // State register
    always_ff @(posedge CLK) begin
        if (RST) begin
            state <= ST_EMPTY;
        end else begin
            state <= next_state;
        end
    end

    // Decoded word register; holds while the datapath stalls
    always_ff @(posedge CLK) begin
        if (RST) begin
            DEC <= '0;
        end else if (take) begin
            DEC <= next_dec;
        end
    end

endmodule

/* testbench/odm_decode_asserts.sv */
// Checker for the decoder: handshake timing and opcode to class mapping.
// Sees only top ports; bound onto every odm_decode instance below.
`timescale 1ns/1ns
module odm_decode_asserts (
    input wire logic              CLK,
    input wire logic              RST,
    input wire logic [23:0]       INSTR,
    input wire logic              INSTR_VALID,
    input wire logic              INSTR_READY,
    input wire logic [23:0]       ACC,
    input wire odm_pkg::odm_dec_s DEC,
    input wire logic              DEC_VALID,
    input wire logic              DEC_READY
);
    import odm_pkg::*;
    // ------------------------------------------------------------
    // Capture of the word taken, judged one edge later
    // ------------------------------------------------------------
    logic        took;     // DEC reflects a word taken last edge
    logic [23:0] cap_ins;  // That word
    logic [23:0] cap_acc;  // Accumulator seen with it
    wire  [5:0]  opc = cap_ins[23:18];
    wire  [23:0] yv  = {9'h0, cap_ins[14:0]};

    // Register the take; cleared by reset so no stale capture is judged
    always_ff @(posedge CLK) begin
        took <= !RST && INSTR_VALID && INSTR_READY;
        if (INSTR_VALID && INSTR_READY) begin
            cap_ins <= INSTR;
            cap_acc <= ACC;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    // Only positive operands: both zeros compare equal otherwise
    property p_skip_ge; took && opc == OPC_SKIP_GE && cap_ins[17:14] == 0 && !cap_acc[23]
        |-> DEC.skip == (cap_acc >= yv); endproperty
    a_skip_ge: assert property (p_skip_ge) else $error("skip flag wrong");
    property p_idx_step; took && opc == OPC_INDEX_SKIP && cap_ins[17:16] != 0 |-> DEC.dest ==
        DEST_IDX && DEC.op == (cap_ins[15] ? OP_IDX_SKIP_DEC : OP_IDX_SKIP_INC); endproperty
    a_idx_step: assert property (p_idx_step) else $error("index step wrong");
    property p_enter; took && opc == OPC_ENTER_CHA
        |-> DEC.dest == DEST_A && DEC.result == {7'h0, cap_ins[16:0]}; endproperty
    a_enter: assert property (p_enter) else $error("char address wrong");
    property p_xor; took && opc == OPC_XOR && cap_ins[17:14] == 0
        |-> DEC.result == (cap_acc ^ yv); endproperty
    a_xor: assert property (p_xor) else $error("xor result wrong");
    property p_and; took && opc == OPC_AND && cap_ins[17:14] == 0
        |-> DEC.result == (cap_acc & yv); endproperty
    a_and: assert property (p_and) else $error("and result wrong");
    property p_double; took && (opc == OPC_LOAD_DBL || opc == OPC_DIVIDE) |-> DEC.dest ==
        DEST_AQ && DEC.op == (opc == OPC_DIVIDE ? OP_DIVIDE_DS : OP_LOAD_DOUBLE); endproperty
    a_double: assert property (p_double) else $error("pair op wrong");
    property p_store_wa; took && opc == OPC_STORE_WA |-> DEC.result ==
        (cap_acc & MASK_WORD_ADDR) && DEC.wmask == MASK_WORD_ADDR; endproperty
    a_store_wa: assert property (p_store_wa) else $error("word store wrong");
    property p_store_ca; took && opc == OPC_STORE_CA |-> DEC.result ==
        (cap_acc & MASK_CHAR_ADDR) && DEC.wmask == MASK_CHAR_ADDR; endproperty
    a_store_ca: assert property (p_store_ca) else $error("char store wrong");
    property p_trap; took |-> DEC.trap == (opc >= OPC_TRAP_LO && opc <= OPC_TRAP_HI);
    endproperty
    a_trap: assert property (p_trap) else $error("trap flag wrong");
    property p_move; took && opc == OPC_MOVE |-> DEC.op == OP_MOVE_CHARS; endproperty
    a_move: assert property (p_move) else $error("move class wrong");
    property p_in; took && opc == OPC_IN_CHAR
        |-> DEC.op == (cap_ins[15] ? OP_IN_CHAR_ACC : OP_IN_CHAR_BLOCK); endproperty
    a_in: assert property (p_in) else $error("input form wrong");
    property p_out; took && opc == OPC_OUT_WORD
        |-> DEC.op == (cap_ins[15] ? OP_OUT_WORD_ACC : OP_OUT_WORD_BLOCK); endproperty
    a_out: assert property (p_out) else $error("output form wrong");
    property p_unused; took && opc == OPC_UNUSED |-> DEC.illegal && DEC.op == OP_NONE;
    endproperty
    a_unused: assert property (p_unused) else $error("unused code not flagged");
    // Handshake: answer one edge after take; refused words leave DEC held
    property p_answer; INSTR_VALID && INSTR_READY |=> DEC_VALID; endproperty
    a_answer: assert property (p_answer) else $error("no answer after take");
    property p_hold; DEC_VALID && !DEC_READY |-> !INSTR_READY ##1 DEC_VALID && $stable(DEC);
    endproperty
    a_hold: assert property (p_hold) else $error("stalled result not held");
endmodule

bind odm_decode odm_decode_asserts u_chk (.*);

/* testbench/odm_datapath_model.sv */
// Execution datapath stand-in: accepts decoded words promptly or slowly.
// Assumes the same clock and synchronous reset as the decoder.
`timescale 1ns/1ns
module odm_datapath_model (
    input  wire logic clk,        // Core clock
    input  wire logic rst,        // Synchronous, active high
    input  wire logic slow,       // Accept only one cycle in four
    output logic      dec_ready   // Datapath accepts DEC
);
    logic [1:0] phase;       // Free-running stall phase

    // Ready does not wait for valid, as a busy datapath would not either
    always_ff @(posedge clk) begin
        if (rst) begin
            phase     <= 2'h0;
            dec_ready <= 1'b0;
        end else begin
            phase     <= phase + 2'h1;
            dec_ready <= !slow || phase == 2'h2;
        end
    end
endmodule

/* testbench/odm_decode_tb_top.sv */
// Self-checking bench: table of words, trapped range, stalls, mid-run reset.
// Assumes odm_pkg, the decoder and the datapath model are compiled first.
`timescale 1ns/1ns
module odm_decode_tb_top;
    import odm_pkg::*;
    typedef struct {
        logic [23:0] ins, acc;
        odm_op_e     op;
        odm_dest_e   dst;
        logic        skp, ill, cd, cr;
        logic [23:0] res, wm;
    } odm_row_s;
    localparam logic [23:0] A0 = 24'h123456;  // Accumulator for most rows
    localparam logic [23:0] Q0 = 24'h654321;  // Q register throughout
    localparam int          NR = 23;          // Table rows
    logic clk = 1'b0, rst = 1'b1, slow = 1'b0, instr_valid = 1'b0, dec_ready;
    logic instr_ready, dec_valid;
    logic [23:0] instr = 24'h0, acc = 24'h0;
    odm_dec_s dec;
    odm_row_s rows [NR];
    odm_row_s expq [$];
    odm_row_s e_row;
    int bad_count = 0, checks_done = 0;

    odm_decode u_dut (.CLK(clk), .RST(rst), .INSTR(instr), .INSTR_VALID(instr_valid),
        .INSTR_READY(instr_ready), .ACC(acc), .QREG(Q0), .IDX(15'h3), .DEC(dec),
        .DEC_VALID(dec_valid), .DEC_READY(dec_ready));
    odm_datapath_model u_dp (.clk(clk), .rst(rst), .slow(slow), .dec_ready(dec_ready));

    initial begin
        forever #4 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [23:0] mk(input logic [5:0] o, input logic [2:0] bf,
                                       input logic [14:0] y);
        return {o, bf, y};
    endfunction

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // Called at a rising edge; returns at the edge that takes the word
    task automatic issue(input odm_row_s r);
        int n;
        n = 0;
        instr       <= r.ins;
        acc         <= r.acc;
        instr_valid <= 1'b1;
        do begin
            @(negedge clk);
            n++;
        end while (instr_ready !== 1'b1 && n < 40);
        if (n >= 40) chk(instr_ready, 24'h1);
        @(posedge clk);
        expq.push_back(r);
    endtask

    task automatic drain(input string name);
        int n;
        instr_valid <= 1'b0;
        for (n = 0; n < 40 && expq.size() != 0; n++) @(posedge clk);
        chk(expq.size(), 24'h0);
        $display("test %s done", name);
    endtask

    // Every accepted result is compared with the oldest word issued
    always @(negedge clk) begin
        if (!rst && dec_valid === 1'b1 && dec_ready === 1'b0)
            chk(instr_ready, 24'h0);
        if (!rst && dec_valid === 1'b1 && dec_ready === 1'b1) begin
            e_row = expq.size() != 0 ? expq.pop_front() : rows[0];
            chk(dec.op, e_row.op);
            chk(dec.opcode, e_row.ins[23:18]);
            chk(dec.trap, e_row.op == OP_TRAP);
            chk(dec.illegal, e_row.ill);
            if (e_row.op inside {OP_SKIP_ACC_GE, OP_IDX_SKIP_INC, OP_IDX_SKIP_DEC})
                chk(dec.skip, e_row.skp);
            if (e_row.cd) chk(dec.dest, e_row.dst);
            if (e_row.cr) chk(dec.result, e_row.res);
            if (e_row.wm !== 24'h0) chk(dec.wmask, e_row.wm);
        end
    end

    task stop_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #50000;
        bad_count++;
        stop_test;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rows = '{
            '{mk(6'o05, 0, 15'h5), 24'h5, OP_SKIP_ACC_GE, DEST_NONE, 1, 0, 0, 0, 0, 0},
            '{mk(6'o05, 0, 15'h5), 24'h4, OP_SKIP_ACC_GE, DEST_NONE, 0, 0, 0, 0, 0, 0},
            '{mk(6'o10, 2, 15'h3), A0, OP_IDX_SKIP_INC, DEST_IDX, 1, 0, 1, 1, 24'h4, 0},
            '{mk(6'o10, 3, 15'h7), A0, OP_IDX_SKIP_DEC, DEST_IDX, 0, 0, 1, 1, 24'h2, 0},
            '{mk(6'o11, 1, 15'h2bcd), A0, OP_ENTER_CHA, DEST_A, 0, 0, 1, 1, 24'h00abcd, 0},
            '{mk(6'o16, 0, 15'hf0f), A0, OP_XOR, DEST_A, 0, 0, 1, 1, A0 ^ 24'hf0f, 0},
            '{mk(6'o16, 1, 15'hf0f), A0, OP_XOR, DEST_Q, 0, 0, 1, 1, Q0 ^ 24'hf0f, 0},
            '{mk(6'o16, 4, 15'hf0f), A0, OP_XOR, DEST_IDX, 0, 0, 1, 0, 0, 0},
            '{mk(6'o17, 0, 15'hf0f), A0, OP_AND, DEST_A, 0, 0, 1, 1, A0 & 24'hf0f, 0},
            '{mk(6'o17, 1, 15'hf0f), A0, OP_AND, DEST_Q, 0, 0, 1, 1, Q0 & 24'hf0f, 0},
            '{mk(6'o25, 0, 15'h10), A0, OP_LOAD_DOUBLE, DEST_AQ, 0, 0, 1, 0, 0, 0},
            '{mk(6'o44, 0, 15'h10), 24'hfedcba, OP_STORE_WORD_ADDR, DEST_MEM, 0, 0, 1, 1,
              24'hfedcba & MASK_WORD_ADDR, MASK_WORD_ADDR},
            '{mk(6'o46, 0, 15'h10), 24'hfedcba, OP_STORE_CHAR_ADDR, DEST_MEM, 0, 0, 1, 1,
              24'hfedcba & MASK_CHAR_ADDR, MASK_CHAR_ADDR},
            '{mk(6'o51, 0, 15'h10), A0, OP_DIVIDE_DS, DEST_AQ, 0, 0, 1, 0, 0, 0},
            '{mk(6'o72, 0, 15'h10), A0, OP_MOVE_CHARS, DEST_NONE, 0, 0, 0, 0, 0, 0},
            '{mk(6'o73, 0, 15'h10), A0, OP_IN_CHAR_BLOCK, DEST_MEM, 0, 0, 1, 0, 0, 0},
            '{mk(6'o73, 1, 15'h10), A0, OP_IN_CHAR_ACC, DEST_A, 0, 0, 1, 0, 0, 0},
            '{mk(6'o76, 0, 15'h10), A0, OP_OUT_WORD_BLOCK, DEST_NONE, 0, 0, 0, 0, 0, 0},
            '{mk(6'o76, 1, 15'h10), A0, OP_OUT_WORD_ACC, DEST_NONE, 0, 0, 0, 1, A0, 0},
            '{mk(6'o55, 0, 15'h0), A0, OP_NONE, DEST_NONE, 0, 1, 0, 0, 0, 0},
            '{mk(6'o77, 5, 15'h4000), A0, OP_NONE, DEST_NONE, 0, 1, 0, 0, 0, 0},
            '{mk(6'o77, 5, 15'h6000), A0, OP_NONE, DEST_NONE, 0, 1, 0, 0, 0, 0},
            '{mk(6'o77, 5, 15'h0000), A0, OP_IO_CONTROL, DEST_NONE, 0, 0, 0, 0, 0, 0}};
        repeat (5) @(negedge clk);
        chk(dec_valid, 24'h0);
        chk(dec.op, OP_NONE);
        chk(instr_ready, 24'h1);
        @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) issue(rows[i]);
        drain("table");
        @(posedge clk);
        // Whole trapped range, back to back
        for (int o = 6'o56; o <= 6'o70; o++)
            issue('{mk(o[5:0], 0, 15'h1), A0, OP_TRAP, DEST_NONE, 0, 0, 0, 0, 0, 0});
        drain("trapped range");
        @(posedge clk);
        // Same table with the datapath stalling, so words are refused
        slow <= 1'b1;
        foreach (rows[i]) issue(rows[i]);
        drain("stalled table");
        @(posedge clk);
        // Reset lands while a result is still held
        issue(rows[5]);
        instr_valid <= 1'b0;
        rst         <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(dec_valid, 24'h0);
        chk(instr_ready, 24'h1);
        expq.delete();
        $display("test mid-run reset done");
        stop_test;
    end
endmodule
